// ### boundary_scan_tap.sv
// Boundary-scan port: TAP controller, instruction and data registers.
// Assumes TCK, TMS, TDI, TRST_N come from the tester; CORE_* from core logic.
`timescale 1ns/100ps
`default_nettype none
module boundary_scan_tap #(
    parameter int IN_W = tap_pkg::IN_W_DEF,
    parameter int OUT_W = tap_pkg::OUT_W_DEF
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic TCK,
    input wire logic TRST_N,
    input wire logic TMS,
    input wire logic TDI,
    output logic TDO,
    output logic TDO_OE,
    input wire logic [IN_W-1:0] PIN_IN,
    input wire logic [OUT_W-1:0] CORE_OUT,
    input wire logic CORE_OE,
    output logic [OUT_W-1:0] PIN_OUT,
    output logic PIN_OE,
    output logic TEST_ACTIVE
);
    import tap_pkg::*;

    localparam int BS_W = IN_W + OUT_W + 1;

    // ==========================================================
    // controller state, test clock rising edge
    tap_state_t st_q, st_d;

    always_comb begin
        st_d = st_q;
        unique case (st_q)
            S_TLR: st_d = TMS ? S_TLR : S_RTI;
            S_RTI: st_d = TMS ? S_SEL_DR : S_RTI;
            S_SEL_DR: st_d = TMS ? S_SEL_IR : S_CAP_DR;
            S_CAP_DR: st_d = TMS ? S_EX1_DR : S_SH_DR;
            S_SH_DR: st_d = TMS ? S_EX1_DR : S_SH_DR;
            S_EX1_DR: st_d = TMS ? S_UPD_DR : S_PAU_DR;
            S_PAU_DR: st_d = TMS ? S_EX2_DR : S_PAU_DR;
            S_EX2_DR: st_d = TMS ? S_UPD_DR : S_SH_DR;
            S_UPD_DR: st_d = TMS ? S_SEL_DR : S_RTI;
            S_SEL_IR: st_d = TMS ? S_TLR : S_CAP_IR;
            S_CAP_IR: st_d = TMS ? S_EX1_IR : S_SH_IR;
            S_SH_IR: st_d = TMS ? S_EX1_IR : S_SH_IR;
            S_EX1_IR: st_d = TMS ? S_UPD_IR : S_PAU_IR;
            S_PAU_IR: st_d = TMS ? S_EX2_IR : S_PAU_IR;
            S_EX2_IR: st_d = TMS ? S_UPD_IR : S_SH_IR;
            S_UPD_IR: st_d = TMS ? S_SEL_DR : S_RTI;
        endcase
    end

    always_ff @(posedge TCK or negedge TRST_N) begin
        if (!TRST_N) begin
            st_q <= S_TLR;
        end else begin
            st_q <= st_d;
        end
    end

    // ==========================================================
    // instruction decode
    logic [IR_W-1:0] ir_q, ir_d;
    logic sel_bs, sel_id, sel_byp;

    always_comb begin
        sel_bs = (ir_q == IR_EXTEST) || (ir_q == IR_SAMPLE);
        sel_id = (ir_q == IR_IDCODE);
        // high-z, bypass and unused codes all pick the bypass stage
        sel_byp = !sel_bs && !sel_id;
    end

    // ==========================================================
    // shift stages and pin samplers, test clock rising edge
    logic [IR_W-1:0] ir_sh_q, ir_sh_d;
    logic byp_q, byp_d;
    logic [BS_W-1:0] bs_sh_q, bs_sh_d;
    logic [ID_W-1:0] id_sh_q, id_sh_d;
    logic [IN_W-1:0] pin_m_q, pin_s_q;
    logic [OUT_W-1:0] cout_m_q, cout_s_q;
    logic coe_m_q, coe_s_q;

    always_comb begin
        ir_sh_d = ir_sh_q;
        byp_d = byp_q;
        bs_sh_d = bs_sh_q;
        id_sh_d = id_sh_q;
        if (st_q == S_CAP_IR) begin
            ir_sh_d = IR_CAPTURE;
        end else if (st_q == S_SH_IR) begin
            ir_sh_d = {TDI, ir_sh_q[IR_W-1:1]};
        end
        // pause and exit states keep every shift stage as it is
        if (st_q == S_CAP_DR) begin
            if (sel_byp) begin
                byp_d = BYPASS_CAPTURE;
            end
            if (sel_bs) begin
                bs_sh_d = {coe_s_q, cout_s_q, pin_s_q};
            end
            if (sel_id) begin
                id_sh_d = ID_WORD;
            end
        end else if (st_q == S_SH_DR) begin
            if (sel_byp) begin
                byp_d = TDI;
            end
            if (sel_bs) begin
                bs_sh_d = {TDI, bs_sh_q[BS_W-1:1]};
            end
            if (sel_id) begin
                id_sh_d = {TDI, id_sh_q[ID_W-1:1]};
            end
        end
    end

    always_ff @(posedge TCK or negedge TRST_N) begin
        if (!TRST_N) begin
            ir_sh_q <= IR_CAPTURE;
            byp_q <= BYPASS_CAPTURE;
            bs_sh_q <= '0;
            id_sh_q <= ID_WORD;
            pin_m_q <= '0;
            pin_s_q <= '0;
            cout_m_q <= '0;
            cout_s_q <= '0;
            coe_m_q <= 1'b0;
            coe_s_q <= 1'b0;
        end else begin
            ir_sh_q <= ir_sh_d;
            byp_q <= byp_d;
            bs_sh_q <= bs_sh_d;
            id_sh_q <= id_sh_d;
            pin_m_q <= PIN_IN;
            pin_s_q <= pin_m_q;
            cout_m_q <= CORE_OUT;
            cout_s_q <= cout_m_q;
            coe_m_q <= CORE_OE;
            coe_s_q <= coe_m_q;
        end
    end

    // ==========================================================
    // latches, serial out and core hand-over, test clock falling edge
    logic tdo_q, tdo_d, tdo_oe_q, tdo_oe_d;
    logic ext_q, ext_d, hz_q, hz_d;
    logic [BS_W-1:0] xfer_q, xfer_d;
    logic req_q, req_d;
    logic ack_m_q, ack_s_q;
    logic ack_q;

    always_comb begin
        ir_d = ir_q;
        xfer_d = xfer_q;
        req_d = req_q;
        if (st_q == S_TLR) begin
            ir_d = IR_IDCODE;
        end else if (st_q == S_UPD_IR) begin
            ir_d = ir_sh_q;
        end
        // a boundary update while the core side is still busy is dropped
        if (st_q == S_UPD_DR && sel_bs && req_q == ack_s_q) begin
            xfer_d = bs_sh_q;
            req_d = !req_q;
        end
        ext_d = (ir_d == IR_EXTEST);
        hz_d = (ir_d == IR_HIGHZ);
        tdo_oe_d = (st_q == S_SH_IR) || (st_q == S_SH_DR);
        tdo_d = 1'b0;
        if (st_q == S_SH_IR) begin
            tdo_d = ir_sh_q[0];
        end else if (st_q == S_SH_DR) begin
            tdo_d = sel_bs ? bs_sh_q[0] : (sel_id ? id_sh_q[0] : byp_q);
        end
    end

    always_ff @(negedge TCK or negedge TRST_N) begin
        if (!TRST_N) begin
            ir_q <= IR_IDCODE;
            xfer_q <= '0;
            req_q <= 1'b0;
            ext_q <= 1'b0;
            hz_q <= 1'b0;
            tdo_q <= 1'b0;
            tdo_oe_q <= 1'b0;
            ack_m_q <= 1'b0;
            ack_s_q <= 1'b0;
        end else begin
            ir_q <= ir_d;
            xfer_q <= xfer_d;
            req_q <= req_d;
            ext_q <= ext_d;
            hz_q <= hz_d;
            tdo_q <= tdo_d;
            tdo_oe_q <= tdo_oe_d;
            ack_m_q <= ack_q;
            ack_s_q <= ack_m_q;
        end
    end

    assign TDO = tdo_q;
    assign TDO_OE = tdo_oe_q;

    // ==========================================================
    // core clock side: mode flags, boundary word, pin drivers
    logic req_m_q, req_s_q, ext_m_q, ext_s_q, hz_m_q, hz_s_q;
    logic ack_d;
    logic [BS_W-1:0] word_q, word_d;
    logic [OUT_W-1:0] pin_out_q, pin_out_d;
    logic pin_oe_q, pin_oe_d, act_q, act_d;

    always_comb begin
        ack_d = ack_q;
        word_d = word_q;
        if (req_s_q != ack_q) begin
            word_d = xfer_q;
            ack_d = req_s_q;
        end
        // outside extest and high-z the core drives its own pins
        pin_out_d = ext_s_q ? word_q[IN_W +: OUT_W] : CORE_OUT;
        pin_oe_d = hz_s_q ? 1'b0 : (ext_s_q ? word_q[BS_W-1] : CORE_OE);
        act_d = ext_s_q || hz_s_q;
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            req_m_q <= 1'b0;
            req_s_q <= 1'b0;
            ext_m_q <= 1'b0;
            ext_s_q <= 1'b0;
            hz_m_q <= 1'b0;
            hz_s_q <= 1'b0;
            ack_q <= 1'b0;
            word_q <= '0;
            pin_out_q <= '0;
            pin_oe_q <= 1'b0;
            act_q <= 1'b0;
        end else if (CE) begin
            req_m_q <= req_q;
            req_s_q <= req_m_q;
            ext_m_q <= ext_q;
            ext_s_q <= ext_m_q;
            hz_m_q <= hz_q;
            hz_s_q <= hz_m_q;
            ack_q <= ack_d;
            word_q <= word_d;
            pin_out_q <= pin_out_d;
            pin_oe_q <= pin_oe_d;
            act_q <= act_d;
        end
    end

    assign PIN_OUT = pin_out_q;
    assign PIN_OE = pin_oe_q;
    assign TEST_ACTIVE = act_q;

    // ==========================================================
    // checks
    chk_five_ones_reset: assert property (
        @(posedge TCK) disable iff (!TRST_N)
        TMS [*5] |=> st_q == S_TLR)
        else $error("five mode-select highs did not reset");
    chk_sel_ir_exit: assert property (
        @(posedge TCK) disable iff (!TRST_N)
        st_q == S_SEL_IR && TMS |=> st_q == S_TLR)
        else $error("select-ir with tms high did not reset");
    chk_ir_capture: assert property (
        @(posedge TCK) disable iff (!TRST_N)
        st_q == S_CAP_IR |=> ir_sh_q[1:0] == 2'b01)
        else $error("capture-ir low bits not 01");
    chk_ir_shift: assert property (
        @(posedge TCK) disable iff (!TRST_N)
        st_q == S_SH_IR |=>
        ir_sh_q == {$past(TDI), $past(ir_sh_q[IR_W-1:1])})
        else $error("shift-ir did not shift in tdi");
    chk_ir_pause: assert property (
        @(posedge TCK) disable iff (!TRST_N)
        st_q == S_PAU_IR |=> $stable(ir_sh_q))
        else $error("pause-ir changed the shift stages");
    chk_ir_update: assert property (
        @(posedge TCK) disable iff (!TRST_N)
        st_q == S_UPD_IR |=> ir_q == $past(ir_sh_q))
        else $error("update-ir did not latch the instruction");
    chk_reset_idcode: assert property (
        @(posedge TCK) disable iff (!TRST_N)
        st_q == S_TLR |=> ir_q == IR_IDCODE && !hz_q && !ext_q)
        else $error("test logic still active in reset state");
    chk_bypass_zero: assert property (
        @(posedge TCK) disable iff (!TRST_N)
        st_q == S_CAP_DR && sel_byp |=> byp_q == 1'b0)
        else $error("bypass did not capture zero");
    chk_id_capture: assert property (
        @(posedge TCK) disable iff (!TRST_N)
        st_q == S_CAP_DR && sel_id |=> id_sh_q == ID_WORD)
        else $error("identification word not captured");
    chk_highz_pins: assert property (
        @(posedge CLK) disable iff (RST)
        hz_s_q && CE |=> !PIN_OE)
        else $error("high-z mode left an output enabled");

endmodule : boundary_scan_tap
`default_nettype wire

// ### boundary_scan_tap_bench.sv
// Self-checking bench for the boundary-scan port.
// Assumes test_controller models the tester on the test port.
`timescale 1ns/100ps
`default_nettype none
module boundary_scan_tap_bench;
    import tap_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic core_oe = 1'b1;
    logic [3:0] pin_in = 4'h3;
    logic [3:0] core_out = 4'h6;
    logic [3:0] pin_out;
    logic tck, trst_n, tms, tdi, tdo, tdo_oe, pin_oe, test_active;
    logic [31:0] d;
    int n_fail = 0;
    int checks_done = 0;

    always #20 clk = ~clk;

    boundary_scan_tap boundary_scan_tap_i (.CLK(clk), .RST(rst), .CE(1'b1),
        .TCK(tck), .TRST_N(trst_n), .TMS(tms), .TDI(tdi), .TDO(tdo),
        .TDO_OE(tdo_oe), .PIN_IN(pin_in), .CORE_OUT(core_out),
        .CORE_OE(core_oe), .PIN_OUT(pin_out), .PIN_OE(pin_oe),
        .TEST_ACTIVE(test_active));
    test_controller test_controller_i (.tck(tck), .trst_n(trst_n),
        .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));

    // =====================================
    // checking and closing
    task automatic chk(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic tally_and_finish;
        $display("checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic settle(input logic act, input logic oe);
        int i;
        i = 0;
        while (i < 20 && !(test_active === act && pin_oe === oe)) begin
            @(negedge clk);
            i++;
        end
        if (!(test_active === act && pin_oe === oe)) begin
            chk("mode flags", 0, 1);
            tally_and_finish();
        end
    endtask : settle

    task automatic ir(input logic [3:0] code);
        test_controller_i.scan(1'b1, 4, {28'h000_0000, code}, 99, d);
        chk("ir capture", d[1:0], 2'b01);
    endtask : ir

    // =====================================
    // scenarios
    task automatic t_power_up;
        test_controller_i.tms_reset();
        test_controller_i.scan(1'b0, 32, 32'h0000_0000, 99, d);
        chk("id after reset", d, ID_WORD);
        @(negedge clk);
        chk("idle test flag", test_active, 1'b0);
        chk("idle pins", pin_out, core_out);
        $display("power up test done");
    endtask : t_power_up

    task automatic t_bypass;
        logic [3:0] codes [2] = '{IR_BYPASS, 4'h7};
        foreach (codes[k]) begin
            ir(codes[k]);
            test_controller_i.scan(1'b0, 8, 32'h0000_00C5, 99, d);
            chk("bypass out", d[7:0], 8'h8A);
            chk("bypass pins", pin_out, core_out);
        end
        $display("bypass test done");
    endtask : t_bypass

    task automatic t_pause;
        test_controller_i.scan(1'b1, 4, 32'h0000_0002, 1, d);
        chk("paused ir capture", d[3:0], IR_CAPTURE);
        test_controller_i.scan(1'b0, 32, 32'h0000_0000, 5, d);
        chk("paused id", d, ID_WORD);
        $display("pause test done");
    endtask : t_pause

    task automatic t_tms_reset;
        ir(IR_BYPASS);
        test_controller_i.tms_reset();
        test_controller_i.scan(1'b0, 32, 32'h0000_0000, 99, d);
        chk("id after tms reset", d, ID_WORD);
        $display("tms reset test done");
    endtask : t_tms_reset

    task automatic t_sample_extest;
        ir(IR_SAMPLE);
        test_controller_i.scan(1'b0, 9, 32'h0000_01A5, 99, d);
        chk("sample word", d[8:0], {core_oe, core_out, pin_in});
        chk("sample pins", pin_out, core_out);
        repeat (4) @(negedge clk);
        ir(IR_EXTEST);
        settle(1'b1, 1'b1);
        chk("extest pins", pin_out, 4'hA);
        $display("sample and extest test done");
    endtask : t_sample_extest

    task automatic t_highz;
        ir(IR_HIGHZ);
        settle(1'b1, 1'b0);
        chk("highz enable", pin_oe, 1'b0);
        test_controller_i.scan(1'b0, 2, 32'h0000_0001, 99, d);
        chk("highz bypass", d[1:0], 2'b10);
        $display("high impedance test done");
    endtask : t_highz

    task automatic t_pin_reset;
        // enter shift-dr so the reset cuts a frame with the serial out driven
        test_controller_i.step(1'b1, 1'b0, d[0]);
        test_controller_i.step(1'b0, 1'b0, d[0]);
        test_controller_i.step(1'b0, 1'b0, d[0]);
        #1;
        chk("serial enable in shift", tdo_oe, 1'b1);
        test_controller_i.pin_reset();
        chk("serial enable in reset", tdo_oe, 1'b0);
        settle(1'b0, 1'b1);
        chk("pins after reset", pin_out, core_out);
        test_controller_i.step(1'b0, 1'b0, d[0]);
        test_controller_i.scan(1'b0, 32, 32'h0000_0000, 99, d);
        chk("id after pin reset", d, ID_WORD);
        $display("pin reset test done");
    endtask : t_pin_reset

    initial begin
        repeat (20) @(negedge clk);
        // the port has no power-up reset, so the tester resets it first
        test_controller_i.pin_reset();
        @(negedge clk);
        rst = 1'b0;
        repeat (2) @(negedge clk);
        t_power_up();
        t_bypass();
        t_pause();
        t_tms_reset();
        t_sample_extest();
        t_highz();
        t_pin_reset();
        tally_and_finish();
    end
endmodule : boundary_scan_tap_bench
`default_nettype wire

// ### tap_pkg.sv
// Constants, state codes and instruction codes of the boundary-scan port.
// Assumes the tester drives the test clock and mode select on that clock.
// Operation
// - Five test clocks with mode select high always reach Test-Logic-Reset.
// - State changes on test clock rise; sampled mode select picks next.
// - In Test-Logic-Reset all test logic is off; device runs normally.
// - Run-Test-Idle acts only for instructions needing it; none do here.
// - Select-DR goes to DR path or Select-IR; Select-IR to IR or reset.
// - Capture-IR loads a fixed pattern whose two low bits are 01.
// - Shift-IR shifts one bit per rising edge from serial input.
// - Exit1-IR goes to Pause-IR or Update-IR by mode select.
// - Pause-IR keeps the instruction shift register unchanged.
// - Exit2-IR goes back to Shift-IR or on to Update-IR.
// - Update-IR latches the instruction on the falling test clock edge.
// - Instruction register has four cells, low bits nearest serial out.
// - Capture-DR loads the selected data register on the rising edge.
// - DR path states mirror IR path states on the selected register.
// - Bypass, boundary and ID registers share serial in and serial out.
// - Bypass is one stage and captures zero in Capture-DR.
// - Bypass selection and shifting leave normal operation untouched.
// - Boundary register loads and reads the device port cells.
// - Codes: 0 extest, 1 sample, 2 ident, 3 high-z, F bypass.
// - Identification register is 32-bit read-only: version, part, maker.
// - High-z instruction disables all outputs and selects bypass.
`default_nettype none
package tap_pkg;

    localparam int IR_W = 4;
    localparam int ID_W = 32;
    localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
    localparam logic [IR_W-1:0] IR_EXTEST = 4'h0;
    localparam logic [IR_W-1:0] IR_SAMPLE = 4'h1;
    localparam logic [IR_W-1:0] IR_IDCODE = 4'h2;
    localparam logic [IR_W-1:0] IR_HIGHZ = 4'h3;
    localparam logic [IR_W-1:0] IR_BYPASS = 4'hF;
    // identity fields: values are arbitrary
    localparam logic [3:0] ID_VERSION = 4'h1;
    localparam logic [15:0] ID_PART = 16'h5A5A;
    localparam logic [10:0] ID_MAKER = 11'h07E;
    localparam logic [0:0] ID_MARK = 1'h1;
    localparam logic [ID_W-1:0] ID_WORD =
        {ID_VERSION, ID_PART, ID_MAKER, ID_MARK};
    localparam logic BYPASS_CAPTURE = 1'h0;
    localparam int IN_W_DEF = 4;
    localparam int OUT_W_DEF = 4;

    typedef enum logic [3:0] {
        S_EX2_DR = 4'b0000,
        S_EX1_DR = 4'b0001,
        S_SH_DR = 4'b0010,
        S_PAU_DR = 4'b0011,
        S_SEL_IR = 4'b0100,
        S_UPD_DR = 4'b0101,
        S_CAP_DR = 4'b0110,
        S_SEL_DR = 4'b0111,
        S_EX2_IR = 4'b1000,
        S_EX1_IR = 4'b1001,
        S_SH_IR = 4'b1010,
        S_PAU_IR = 4'b1011,
        S_RTI = 4'b1100,
        S_UPD_IR = 4'b1101,
        S_CAP_IR = 4'b1110,
        S_TLR = 4'b1111
    } tap_state_t;

endpackage : tap_pkg
`default_nettype wire

// ### test_controller.sv
// Model of the external boundary-scan tester that drives the test port.
// Assumes the port samples mode select and serial in on the test clock rise.
`timescale 1ns/100ps
`default_nettype none
module test_controller (
    output logic tck,
    output logic trst_n,
    output logic tms,
    output logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe
);
    initial begin
        tck = 1'b0;
        trst_n = 1'b1;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // =====================================
    // one test clock, held low between frames
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #3;
        // a released serial out reads as the inverse of its last level
        q = tdo_oe ? tdo : ~tdo;
        tck = 1'b1;
        #3;
        tck = 1'b0;
    endtask : step

    task automatic tms_reset;
        logic b;
        repeat (5) step(1'b1, ~tdi, b);
        step(1'b0, ~tdi, b);
    endtask : tms_reset

    task automatic pin_reset;
        trst_n = 1'b0;
        #10;
        trst_n = 1'b1;
        #3;
    endtask : pin_reset

    // scan from run-test-idle back to it, optionally pausing after bit p
    task automatic scan(input bit ir, input int n, input logic [31:0] din,
        input int p, output logic [31:0] dout);
        logic b;
        dout = '0;
        step(1'b1, ~tdi, b);
        if (ir) step(1'b1, ~tdi, b);
        step(1'b0, ~tdi, b);
        step(1'b0, ~tdi, b);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1 || i == p, din[i], dout[i]);
            if (i == p && i != n - 1) begin
                step(1'b0, ~tdi, b);
                step(1'b0, ~tdi, b);
                step(1'b1, ~tdi, b);
                step(1'b0, ~tdi, b);
            end
        end
        step(1'b1, ~tdi, b);
        step(1'b0, ~tdi, b);
        tdi = ~tdi;
    endtask : scan
endmodule : test_controller
`default_nettype wire
